/* File: spv_map.svh */
// register map, field positions and timing constants of the serial register port
`ifndef SPV_MAP_SVH
`define SPV_MAP_SVH

// ****************************************************************
// command word layout
// ****************************************************************
`define SPV_WORD_W        16
`define SPV_CNT_W         4
`define SPV_WR_BIT        15
`define SPV_ADDR_HI       14
`define SPV_ADDR_LO       8
`define SPV_DATA_HI       7
`define SPV_DATA_LO       0
`define SPV_LAST_BIT      4'h0f

// ****************************************************************
// register space
// ****************************************************************
`define SPV_NUM_REGS      33
`define SPV_IDX_W         6
`define SPV_IDX_LAST      6'h20
`define SPV_GLOB_IDX      6'h1f
`define SPV_SAVE_BIT      4
`define SPV_BACKUP_MASK   33'h1_5e1f_c3ef
`define SPV_RDONLY_MASK   33'h1_4000_1fe1
`define SPV_BUF_FIRST     6'h0a
`define SPV_BUF_LAST      6'h0c
`define SPV_BUF_DEFAULT   16'h8000
`define SPV_ZERO_WORD     16'h0000

// ****************************************************************
// timing
// ****************************************************************
`define SPV_CLK_PERIOD_NS 25
`define SPV_TSTALL_NS     15400
`define SPV_TSTALL_CYC    ((`SPV_TSTALL_NS + `SPV_CLK_PERIOD_NS - 1) / `SPV_CLK_PERIOD_NS)

`endif

/* File: spv_pkg.sv */
// types and helpers shared by the serial register port modules
`default_nettype none
package spv_pkg;

  typedef enum logic [1:0] {
    SPV_LOAD,
    SPV_RUN,
    SPV_SAVE
  } spv_state_t;

  typedef logic [15:0] spv_word_t;

  function automatic logic spv_bit_of(input logic [32:0] mask, input logic [5:0] idx);
    logic r;
    r = 1'b0;
    if (idx <= 6'h20) begin
      r = mask[idx];
    end
    return r;
  endfunction : spv_bit_of

endpackage : spv_pkg
`default_nettype wire

/* File: spv_link_if.sv */
// carrier between the serial-clock shifter and the core
`timescale 1ns/1ps
`default_nettype none
interface spv_link_if;
  spv_pkg::spv_word_t rx_word;
  logic               rx_tgl;
  spv_pkg::spv_word_t tx_word;

  modport link (output rx_word, output rx_tgl, input tx_word);
  modport core (input rx_word, input rx_tgl, output tx_word);
endinterface : spv_link_if
`default_nettype wire

/* File: spv_link.sv */
// serial-clock domain shifter: mode 3, msb first, 16-bit words
`timescale 1ns/1ps
`default_nettype none
`include "spv_map.svh"
module spv_link (
  input  wire logic sclk,
  input  wire logic lrst,
  input  wire logic cs_n,
  input  wire logic din,
  output var  logic dout,
  spv_link_if.link  lk
);

  logic                   clr;
  logic [`SPV_CNT_W-1:0]  cnt_r,  cnt_nxt;
  spv_pkg::spv_word_t     sh_r,   sh_nxt;
  spv_pkg::spv_word_t     rxw_r,  rxw_nxt;
  logic                   tgl_r,  tgl_nxt;
  spv_pkg::spv_word_t     osh_r,  osh_nxt;
  logic                   dout_r, dout_nxt;

  // select high clears the bit position so a half word never counts
  assign clr = lrst | cs_n;

  // ****************************************************************
  // rising edge: sample input
  // ****************************************************************
  always_comb begin
    sh_nxt  = {sh_r[`SPV_WORD_W-2:0], din};
    cnt_nxt = cnt_r + 1'b1;
    rxw_nxt = rxw_r;
    tgl_nxt = tgl_r;
    if (cnt_r == `SPV_LAST_BIT) begin
      rxw_nxt = sh_nxt;
      tgl_nxt = ~tgl_r;
    end
  end

  always_ff @(posedge sclk or posedge clr) begin
    if (clr) begin
      cnt_r <= '0;
      sh_r  <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      sh_r  <= sh_nxt;
    end
  end

  // the toggle survives select so a finished word is never lost
  always_ff @(posedge sclk or posedge lrst) begin
    if (lrst) begin
      rxw_r <= '0;
      tgl_r <= 1'b0;
    end else begin
      rxw_r <= rxw_nxt;
      tgl_r <= tgl_nxt;
    end
  end

  // ****************************************************************
  // falling edge: shift output
  // ****************************************************************
  always_comb begin
    if (cnt_r == '0) begin
      dout_nxt = lk.tx_word[`SPV_WORD_W-1];
      osh_nxt  = {lk.tx_word[`SPV_WORD_W-2:0], 1'b0};
    end else begin
      dout_nxt = osh_r[`SPV_WORD_W-1];
      osh_nxt  = {osh_r[`SPV_WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or posedge clr) begin
    if (clr) begin
      osh_r  <= '0;
      dout_r <= 1'b0;
    end else begin
      osh_r  <= osh_nxt;
      dout_r <= dout_nxt;
    end
  end

  assign dout       = dout_r;
  assign lk.rx_word = rxw_r;
  assign lk.rx_tgl  = tgl_r;

endmodule : spv_link
`default_nettype wire

/* File: spv_top.sv */
// serial register port with sram working copy and flash backup
`timescale 1ns/1ps
`default_nettype none
`include "spv_map.svh"
module spv_top (
  input  wire logic                   CLK,
  input  wire logic                   RST,
  input  wire logic                   SCLK,
  input  wire logic                   CS_N,
  input  wire logic                   DIN,
  output var  logic                   DOUT,
  output var  logic                   DOUT_OE,
  input  wire logic [`SPV_IDX_W-1:0]  CFG_SEL,
  output var  logic [15:0]            CFG_DATA,
  output var  logic                   CFG_READY
);

  localparam int N = `SPV_NUM_REGS;

  spv_link_if lk ();

  logic                    dout_w;
  spv_pkg::spv_state_t     st_r,   st_nxt;
  logic [`SPV_IDX_W-1:0]   idx_r,  idx_nxt;
  logic                    s1_r,   s2_r,   s3_r;
  spv_pkg::spv_word_t      tx_r,   tx_nxt;
  spv_pkg::spv_word_t      cfg_r,  cfg_nxt;
  spv_pkg::spv_word_t      sram_r  [N];
  spv_pkg::spv_word_t      sram_nxt[N];
  spv_pkg::spv_word_t      flash_r [N];
  spv_pkg::spv_word_t      flash_nxt[N];
  logic                    evt;
  logic                    cmd_wr;
  logic [`SPV_IDX_W-1:0]   cmd_idx;
  logic                    cmd_hi;
  logic [7:0]              cmd_dat;
  logic                    save_req;

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  // an index that holds a stored word; the command register keeps nothing
  function automatic logic spv_mapped(input logic [`SPV_IDX_W-1:0] i);
    return (i <= `SPV_IDX_LAST) && (i != `SPV_GLOB_IDX);
  endfunction : spv_mapped

  // reload and save walk one word per cycle and stop after the last index
  function automatic logic spv_walk_done(input logic [`SPV_IDX_W-1:0] i);
    return (i == `SPV_IDX_LAST);
  endfunction : spv_walk_done

  // ****************************************************************
  // serial clock domain
  // ****************************************************************
  spv_link u_link (
    .sclk (SCLK),
    .lrst (RST),
    .cs_n (CS_N),
    .din  (DIN),
    .dout (dout_w),
    .lk   (lk.link)
  );

  assign DOUT    = dout_w;
  assign DOUT_OE = ~CS_N;

  // ****************************************************************
  // word event crossing
  // ****************************************************************
  // rx_word is stable before the toggle is seen and long after, since the stall keeps the next word off
  always_ff @(posedge CLK) begin
    if (RST) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= lk.rx_tgl;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign evt      = (s2_r != s3_r) && (st_r != spv_pkg::SPV_LOAD);
  assign cmd_wr   = lk.rx_word[`SPV_WR_BIT];
  assign cmd_idx  = lk.rx_word[`SPV_ADDR_HI:`SPV_ADDR_LO+1];
  assign cmd_hi   = lk.rx_word[`SPV_ADDR_LO];
  assign cmd_dat  = lk.rx_word[`SPV_DATA_HI:`SPV_DATA_LO];
  assign save_req = evt && cmd_wr && cmd_hi && (cmd_idx == `SPV_GLOB_IDX)
                    && cmd_dat[`SPV_SAVE_BIT];

  // ****************************************************************
  // core state, sram and flash
  // ****************************************************************
  always_comb begin
    st_nxt  = st_r;
    idx_nxt = idx_r;
    tx_nxt  = tx_r;
    for (int i = 0; i < N; i++) begin
      sram_nxt[i]  = sram_r[i];
      flash_nxt[i] = flash_r[i];
    end
    case (st_r)
      spv_pkg::SPV_LOAD: begin
        if (spv_pkg::spv_bit_of(`SPV_BACKUP_MASK, idx_r)) begin
          sram_nxt[idx_r] = flash_r[idx_r];
        end else if (idx_r >= `SPV_BUF_FIRST && idx_r <= `SPV_BUF_LAST) begin
          sram_nxt[idx_r] = `SPV_BUF_DEFAULT;
        end else begin
          sram_nxt[idx_r] = `SPV_ZERO_WORD;
        end
        idx_nxt = idx_r + 1'b1;
        if (spv_walk_done(idx_r)) begin
          idx_nxt = '0;
          st_nxt  = spv_pkg::SPV_RUN;
        end
      end
      spv_pkg::SPV_SAVE: begin
        if (spv_pkg::spv_bit_of(`SPV_BACKUP_MASK, idx_r)) begin
          flash_nxt[idx_r] = sram_r[idx_r];
        end
        idx_nxt = idx_r + 1'b1;
        if (spv_walk_done(idx_r)) begin
          idx_nxt = '0;
          st_nxt  = spv_pkg::SPV_RUN;
        end
      end
      spv_pkg::SPV_RUN: begin
        if (save_req) begin
          idx_nxt = '0;
          st_nxt  = spv_pkg::SPV_SAVE;
        end
      end
      default: begin
        st_nxt  = spv_pkg::SPV_LOAD;
        idx_nxt = '0;
      end
    endcase
    if (evt) begin
      if (cmd_wr) begin
        tx_nxt = `SPV_ZERO_WORD;
        if (spv_mapped(cmd_idx) && !spv_pkg::spv_bit_of(`SPV_RDONLY_MASK, cmd_idx)) begin
          if (cmd_hi) begin
            sram_nxt[cmd_idx][15:8] = cmd_dat;
          end else begin
            sram_nxt[cmd_idx][7:0] = cmd_dat;
          end
        end
      end else if (spv_mapped(cmd_idx)) begin
        tx_nxt = sram_r[cmd_idx];
      end else begin
        tx_nxt = `SPV_ZERO_WORD;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r  <= spv_pkg::SPV_LOAD;
      idx_r <= '0;
      tx_r  <= '0;
      for (int i = 0; i < N; i++) begin
        sram_r[i] <= '0;
      end
    end else begin
      st_r  <= st_nxt;
      idx_r <= idx_nxt;
      tx_r  <= tx_nxt;
      for (int i = 0; i < N; i++) begin
        sram_r[i] <= sram_nxt[i];
      end
    end
  end

  // flash is nonvolatile: reset never touches it
  always_ff @(posedge CLK) begin
    for (int i = 0; i < N; i++) begin
      flash_r[i] <= flash_nxt[i];
    end
  end

  assign lk.tx_word = tx_r;

  // ****************************************************************
  // configuration view for the rest of the sensor
  // ****************************************************************
  always_comb begin
    cfg_nxt = `SPV_ZERO_WORD;
    if (CFG_SEL <= `SPV_IDX_LAST) begin
      cfg_nxt = sram_r[CFG_SEL];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign CFG_DATA  = cfg_r;
  assign CFG_READY = (st_r != spv_pkg::SPV_LOAD);

endmodule : spv_top
`default_nettype wire

/* File: spv_top_props.sv */
// concurrent checks on the ports of the serial register port
`timescale 1ns/1ps
`default_nettype none
`include "spv_map.svh"
module spv_top_props (
  input wire logic                  CLK,
  input wire logic                  RST,
  input wire logic                  SCLK,
  input wire logic                  CS_N,
  input wire logic                  DIN,
  input wire logic                  DOUT,
  input wire logic                  DOUT_OE,
  input wire logic [`SPV_IDX_W-1:0] CFG_SEL,
  input wire logic [15:0]           CFG_DATA,
  input wire logic                  CFG_READY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // a late write lands within six cycles of the last bit, so eight quiet cycles suffice
  sequence quiet_s;
    (CS_N && CFG_READY && $stable(CFG_SEL)) [*8];
  endsequence
  sequence release_s;
    $fell(RST);
  endsequence
  AST_OE_FOLLOWS_SELECT: assert property (DOUT_OE == !CS_N)
    else $error("output enable differs from select");
  AST_READY_LOW_AT_LOAD: assert property (release_s |-> !CFG_READY [*8])
    else $error("ready before reload");
  AST_READY_RISES: assert property (release_s |-> ##[31:35] CFG_READY)
    else $error("reload did not finish in time");
  AST_READY_HOLDS: assert property (CFG_READY |=> CFG_READY)
    else $error("ready dropped");
  AST_DATA_CLEARED: assert property (release_s |-> CFG_DATA == 16'h0000)
    else $error("view not cleared by reset");
  AST_VIEW_OUT_OF_MAP: assert property ((CFG_SEL > 6'h20) |=> CFG_DATA == 16'h0000)
    else $error("view of unmapped index not zero");
  AST_DOUT_FIRST_BIT: assert property ($fell(CS_N) && SCLK |-> DOUT == 1'b0)
    else $error("output not zero before first falling edge");
  AST_DOUT_ON_FALL: assert property (!CS_N && !$past(CS_N) && $stable(SCLK) |-> $stable(DOUT))
    else $error("output moved without a falling edge");
  AST_QUIET_KEEPS_SRAM: assert property (quiet_s |=> $stable(CFG_DATA))
    else $error("register changed while deselected");
endmodule : spv_top_props
bind spv_top spv_top_props i_props (.CLK(CLK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N),
  .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .CFG_SEL(CFG_SEL), .CFG_DATA(CFG_DATA),
  .CFG_READY(CFG_READY));
`default_nettype wire

/* File: spv_host.sv */
// behavioural serial master facing the register port
`timescale 1ns/1ps
`default_nettype none
module spv_host (
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic din,
  input  wire logic dout,
  input  wire logic dout_oe
);
  logic seen = 1'b0;
  // select starts low for a moment so the first reset meets a clean clear edge
  initial begin
    sclk = 1'b1;
    cs_n = 1'b0;
    din  = 1'b0;
    #2;
    cs_n = 1'b1;
  end
  task automatic xfer(input spv_pkg::spv_word_t w, input int nbits, input logic sel,
                      output spv_pkg::spv_word_t r);
    r    = 16'h0000;
    cs_n = ~sel;
    #100;
    for (int i = 15; i > 15 - nbits; i--) begin
      sclk = 1'b0;
      din  = w[i];
      #80;
      sclk = 1'b1;
      // a released line is read as the inverse of the last bit
      seen = dout_oe ? dout : ~seen;
      r[i] = seen;
      #80;
    end
    #100;
    cs_n = 1'b1;
    din  = ~din;
    #15500;
  endtask : xfer
endmodule : spv_host
`default_nettype wire

/* File: tb.sv */
// self-checking bench of the serial register port
`timescale 1ns/1ps
`default_nettype none
`include "spv_map.svh"
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", nm, e, a); n_mismatch++; end end
module tb;
  logic                  CLK = 1'b0;
  logic                  RST = 1'b0;
  logic                  SCLK, CS_N, DIN, DOUT, DOUT_OE, CFG_READY;
  // a non-backed index keeps the view defined before the first save
  logic [`SPV_IDX_W-1:0] CFG_SEL = 6'h0d;
  logic [15:0]           CFG_DATA;
  spv_pkg::spv_word_t    r, v;
  int                    n_mismatch = 0;
  int                    tests_run = 0;
  always #12.5 CLK = ~CLK;
  spv_top i_dut (.CLK(CLK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT),
    .DOUT_OE(DOUT_OE), .CFG_SEL(CFG_SEL), .CFG_DATA(CFG_DATA), .CFG_READY(CFG_READY));
  spv_host i_host (.sclk(SCLK), .cs_n(CS_N), .din(DIN), .dout(DOUT), .dout_oe(DOUT_OE));
  task automatic x(input spv_pkg::spv_word_t w);
    i_host.xfer(w, 16, 1'b1, r);
  endtask : x
  task automatic view(input logic [`SPV_IDX_W-1:0] idx);
    @(posedge CLK);
    #1 CFG_SEL = idx;
    repeat (2) @(posedge CLK);
    #1 v = CFG_DATA;
  endtask : view
  task automatic do_reset();
    int k;
    @(posedge CLK);
    #1 RST = 1'b1;
    repeat (10) @(posedge CLK);
    #1 RST = 1'b0;
    repeat (20) @(posedge CLK);
    #1 `CHK("ready_load", 1'b0, CFG_READY)
    k = 0;
    while (CFG_READY !== 1'b1 && k < 60) begin
      @(posedge CLK);
      #1 k++;
    end
    `CHK("ready_up", 1'b1, CFG_READY)
  endtask : do_reset
  task automatic t_reload();
    view(6'h0a); `CHK("idx10", 16'h8000, v)
    view(6'h0c); `CHK("idx12", 16'h8000, v)
    view(6'h0d); `CHK("idx13", 16'h0000, v)
    view(6'h3f); `CHK("unmapped", 16'h0000, v)
  endtask : t_reload
  task automatic t_bytes();
    x(16'h83ab);
    x(16'h82cd); `CHK("wr_reply", 16'h0000, r)
    view(6'h01); `CHK("sram1", 16'habcd, v)
    x(16'h0200);
    x(16'h0300); `CHK("rd_even", 16'habcd, r)
    x(16'h8312); `CHK("rd_odd", 16'habcd, r)
    view(6'h01); `CHK("upper_only", 16'h12cd, v)
    x(16'h0000); `CHK("after_wr", 16'h0000, r)
  endtask : t_bytes
  task automatic t_readonly();
    x(16'h9455);
    x(16'h1400);
    x(16'h7f00); `CHK("ro_kept", 16'h8000, r)
    x(16'h0000); `CHK("rd_unmapped", 16'h0000, r)
  endtask : t_readonly
  task automatic t_deselect();
    i_host.xfer(16'h9bff, 8, 1'b1, r);
    i_host.xfer(16'h9baa, 16, 1'b0, r);
    `CHK("oe_idle", 1'b0, DOUT_OE)
    x(16'h1a00);
    x(16'h0000); `CHK("no_partial", 16'h0000, r)
    view(6'h0d); `CHK("idx13_kept", 16'h0000, v)
  endtask : t_deselect
  task automatic t_save();
    x(16'hbf10);
    x(16'h8311);
    x(16'h9b22);
    view(6'h01); `CHK("sram_new", 16'h11cd, v)
    view(6'h0d); `CHK("sram13", 16'h2200, v)
    do_reset();
    view(6'h01); `CHK("flash1", 16'h12cd, v)
    view(6'h0d); `CHK("volatile13", 16'h0000, v)
  endtask : t_save
  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // about 17 words of 18.3 us each plus resets; roughly three times that margin
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    #1 RST = 1'b1;
    do_reset();
    t_reload();
    t_bytes();
    t_readonly();
    t_deselect();
    t_save();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
